/* shared/spip_consts.vh */
`ifndef SPIP_CONSTS_VH
`define SPIP_CONSTS_VH
// port count and clock
`define SPIP_NPORT        4
`define SPIP_CLK_HZ       20000000
// storm inspection interval, in microseconds, and its cycle count
`define SPIP_INSPECT_US   1000
`define SPIP_INSPECT_CYC  (`SPIP_CLK_HZ / 1000000 * `SPIP_INSPECT_US)
// inspection intervals in one second, for the learning rate window
`define SPIP_TICKS_SEC    10'h3e8
// frame class codes
`define SPIP_CLS_KNOWN    2'h0
`define SPIP_CLS_BC       2'h1
`define SPIP_CLS_UMC      2'h2
`define SPIP_CLS_UUC      2'h3
// global register byte offsets
`define SPIP_A_CTRL       8'h00
`define SPIP_A_MTU        8'h04
`define SPIP_A_SECRATE    8'h08
`define SPIP_A_ISTAT      8'h0c
`define SPIP_A_ICLR       8'h10
`define SPIP_A_IEN        8'h14
`define SPIP_A_PSTAT      8'h18
`define SPIP_A_SHUTCLR    8'h1c
// per-port blocks: base 0x40, stride 0x20, word index inside
`define SPIP_PB_FIRST     3'h2
`define SPIP_PB_LAST      3'h5
`define SPIP_PW_CFG       3'h0
`define SPIP_PW_VIOL      3'h4
// per-port config fields (class enables sit at the class codes)
`define SPIP_CFG_STORM    0
`define SPIP_CFG_SHUT     4
`define SPIP_CFG_PROT     5
`define SPIP_CFG_EEE      6
`define SPIP_CFG_SEC      7
`define SPIP_CFG_VSHUT    8
// global control field
`define SPIP_CTRL_SEC     0
// limits and resets
`define SPIP_MTU_DEF      14'h05f2
`define SPIP_MTU_MIN      14'h05ee
`define SPIP_MTU_MAX      14'h2710
`define SPIP_RATE_DEF     24'h002710
`define SPIP_RATE_MIN     24'h000010
`define SPIP_RATE_MAX     24'h989680
`define SPIP_SEC_DEF      10'h064
`define SPIP_SEC_MIN      10'h001
`define SPIP_SEC_MAX      10'h258
`endif

/* rtl/spip_meter.v */
`timescale 1ns/1ps
`include "spip_consts.vh"
// one storm meter: bits of one class on one port per inspection interval
module spip_meter (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // interval pulse and class enable
  input  wire        tick,
  input  wire        en,
  // received frame of this class
  input  wire        add,
  input  wire [13:0] len,
  // threshold in kbps, equal to bits per 1 ms interval
  input  wire [23:0] thresh,
  // results
  output reg         over,
  output wire        trip
);
  wire [31:0] bits;   // frame length in bits
  reg  [31:0] acc;    // bits seen this interval

  assign bits = {15'h0000, len, 3'b000};
  // average over the interval exceeds the ceiling
  assign trip = tick & en & (acc > {8'h00, thresh});

  // accumulate, judge at interval end, restart with the frame in hand
  always @(posedge clock) begin
    if (rst) begin
      acc  <= 32'h00000000;
      over <= 1'b0;
    end else if (tick) begin
      acc  <= add ? bits : 32'h00000000;
      over <= trip;
    end else if (add) begin
      acc  <= acc + bits;
    end
  end
endmodule

/* rtl/spip_sec.v */
`timescale 1ns/1ps
`include "spip_consts.vh"
// source address lock of one port: one permitted address
module spip_sec (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // lock enabled, frame from this port, its source address
  input  wire        en,
  input  wire        hit,
  input  wire [47:0] sa,
  // learning budget left this second
  input  wire        learn_ok,
  // decision
  output wire        viol,
  output wire        learn,
  output wire        pass,
  output wire [15:0] cnt
);
  reg  [47:0] mac_reg;  // permitted source
  reg         ok_reg;   // address recorded
  reg  [15:0] cnt_reg;  // violations, saturating
  wire        match;

  assign match = ok_reg & (sa == mac_reg);
  assign viol  = en & hit & ok_reg & ~match;
  assign learn = en & hit & ~ok_reg & learn_ok;
  // an unknown source with no budget left is held back too
  assign pass  = ~en | match | (~ok_reg & learn_ok);
  assign cnt   = cnt_reg;

  // record first source, count offenders; disabling forgets the address
  always @(posedge clock) begin
    if (rst) begin
      mac_reg <= 48'h000000000000;
      ok_reg  <= 1'b0;
      cnt_reg <= 16'h0000;
    end else if (!en) begin
      ok_reg  <= 1'b0;
    end else begin
      if (learn) begin
        mac_reg <= sa;
        ok_reg  <= 1'b1;
      end
      if (viol && cnt_reg != 16'hffff)
        cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule

/* rtl/spip_top.v */
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "spip_consts.vh"
module spip_top #(
  parameter INSPECT_CYC = `SPIP_INSPECT_CYC
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // avalon-mm register slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // received frame descriptor, one per cycle at most
  input  wire        in_valid,
  input  wire [1:0]  in_port,
  input  wire [1:0]  in_class,
  input  wire [13:0] in_len,
  input  wire [47:0] in_sa,
  input  wire [3:0]  in_dst_mask,
  // forwarding verdict
  output reg         out_valid,
  output reg  [1:0]  out_port,
  output reg  [3:0]  out_mask,
  output reg         out_drop,
  // port state and interrupt
  output reg  [3:0]  port_shut,
  output reg  [3:0]  eee_lpi,
  output reg         irq
);
  ////////////////////////////////////////////////////////////////
  // storage
  reg  [8:0]  cfg_reg [0:3];      // per-port config
  reg  [23:0] rate_reg [0:15];    // thresholds at {port,class}
  reg  [0:0]  ctrl_reg;           // global security enable
  reg  [13:0] mtu_reg;            // max frame length
  reg  [9:0]  secrate_reg;        // learns per second
  reg  [8:0]  istat_reg;          // sticky events
  reg  [8:0]  ien_reg;            // interrupt enables
  reg  [31:0] tick_cnt_reg;       // interval divider
  reg  [9:0]  sec_win_reg;        // intervals into this second
  reg  [9:0]  learn_cnt_reg;      // learns this second
  reg  [3:0]  seen_reg;           // port activity this interval
  reg  [31:0] rd_next;            // read mux
  wire        tick;
  wire        sec_tick;
  wire [15:0] over_w;
  wire [15:0] trip_w;
  wire [3:0]  viol_w;
  wire [3:0]  learn_w;
  wire [3:0]  pass_w;
  wire [63:0] vcnt_w;
  wire [3:0]  storm_ev;
  wire        wr_fire;
  wire        pblk;
  wire [2:0]  pidx3;
  wire [1:0]  pidx;
  wire [2:0]  pword;
  integer     i;
  integer     j;
  integer     n;

  ////////////////////////////////////////////////////////////////
  // helpers: clamp written values into their legal ranges
  function [23:0] clamp_rate;
    input [31:0] v;
    begin
      if (v < {8'h00, `SPIP_RATE_MIN})
        clamp_rate = `SPIP_RATE_MIN;
      else if (v > {8'h00, `SPIP_RATE_MAX})
        clamp_rate = `SPIP_RATE_MAX;
      else
        clamp_rate = v[23:0];
    end
  endfunction

  function [13:0] clamp_mtu;
    input [31:0] v;
    begin
      if (v < {18'h00000, `SPIP_MTU_MIN})
        clamp_mtu = `SPIP_MTU_MIN;
      else if (v > {18'h00000, `SPIP_MTU_MAX})
        clamp_mtu = `SPIP_MTU_MAX;
      else
        clamp_mtu = v[13:0];
    end
  endfunction

  function [9:0] clamp_sec;
    input [31:0] v;
    begin
      if (v < {22'h000000, `SPIP_SEC_MIN})
        clamp_sec = `SPIP_SEC_MIN;
      else if (v > {22'h000000, `SPIP_SEC_MAX})
        clamp_sec = `SPIP_SEC_MAX;
      else
        clamp_sec = v[9:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // interval and one-second enables from a single divider
  assign tick     = (tick_cnt_reg == INSPECT_CYC - 1);
  assign sec_tick = tick & (sec_win_reg == `SPIP_TICKS_SEC - 10'h001);

  always @(posedge clock) begin
    if (rst) begin
      tick_cnt_reg <= 32'h00000000;
      sec_win_reg  <= 10'h000;
    end else if (tick) begin
      tick_cnt_reg <= 32'h00000000;
      sec_win_reg  <= sec_tick ? 10'h000 : sec_win_reg + 10'h001;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // storm meters and source locks, per port and class
  genvar gp, gc;
  generate
    for (gp = 0; gp < `SPIP_NPORT; gp = gp + 1) begin : g_port
      for (gc = 1; gc < 4; gc = gc + 1) begin : g_cls
        spip_meter u_meter (
          .clock  (clock),
          .rst    (rst),
          .tick   (tick),
          .en     (cfg_reg[gp][`SPIP_CFG_STORM] & cfg_reg[gp][gc]),
          .add    (in_valid && in_port == gp && in_class == gc),
          .len    (in_len),
          .thresh (rate_reg[gp*4+gc]),
          .over   (over_w[gp*4+gc]),
          .trip   (trip_w[gp*4+gc])
        );
      end
      // class code zero is never policed
      assign over_w[gp*4] = 1'b0;
      assign trip_w[gp*4] = 1'b0;
      assign storm_ev[gp] = |trip_w[gp*4+3:gp*4];
      spip_sec u_sec (
        .clock    (clock),
        .rst      (rst),
        .en       (ctrl_reg[`SPIP_CTRL_SEC] & cfg_reg[gp][`SPIP_CFG_SEC]),
        .hit      (in_valid && in_port == gp),
        .sa       (in_sa),
        .learn_ok (learn_cnt_reg < secrate_reg),
        .viol     (viol_w[gp]),
        .learn    (learn_w[gp]),
        .pass     (pass_w[gp]),
        .cnt      (vcnt_w[gp*16+15:gp*16])
      );
    end
  endgenerate

  // learning budget, refilled each second
  always @(posedge clock) begin
    if (rst)
      learn_cnt_reg <= 10'h000;
    else if (sec_tick)
      learn_cnt_reg <= 10'h000;
    else if (|learn_w)
      learn_cnt_reg <= learn_cnt_reg + 10'h001;
  end

  ////////////////////////////////////////////////////////////////
  // frame verdict, computed from the source port's settings
  wire [8:0] scfg;
  wire       oversize;
  wire       storm_drop;
  wire       drop_now;
  wire [3:0] prot_mask;
  wire [3:0] base_mask;
  wire [3:0] self_mask;
  wire [3:0] fwd_mask;

  assign scfg       = cfg_reg[in_port];
  assign oversize   = in_len > mtu_reg;
  // storm state persists for the interval after the one that tripped
  assign storm_drop = scfg[`SPIP_CFG_STORM] & scfg[in_class] & over_w[{in_port, in_class}]
                      & ~scfg[`SPIP_CFG_SHUT];
  assign drop_now   = port_shut[in_port] | oversize | storm_drop | ~pass_w[in_port];
  assign prot_mask  = {cfg_reg[3][`SPIP_CFG_PROT], cfg_reg[2][`SPIP_CFG_PROT],
                       cfg_reg[1][`SPIP_CFG_PROT], cfg_reg[0][`SPIP_CFG_PROT]};
  // unresolved classes go to every other port
  assign base_mask  = (in_class == `SPIP_CLS_KNOWN) ? in_dst_mask : 4'hf;
  assign self_mask  = 4'h1 << in_port;
  assign fwd_mask   = base_mask & ~self_mask & ~port_shut
                      & (scfg[`SPIP_CFG_PROT] ? ~prot_mask : 4'hf);

  // register the verdict; a dropped frame reaches no port
  always @(posedge clock) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_port  <= 2'h0;
      out_mask  <= 4'h0;
      out_drop  <= 1'b0;
    end else begin
      out_valid <= in_valid;
      out_port  <= in_port;
      out_mask  <= (in_valid && !drop_now) ? fwd_mask : 4'h0;
      out_drop  <= in_valid & drop_now;
    end
  end

  ////////////////////////////////////////////////////////////////
  // shutdown state: set wins over a clear in the same cycle
  reg [3:0] shut_set;
  reg [3:0] shut_clr;
  always @* begin
    shut_set = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (storm_ev[i] && cfg_reg[i][`SPIP_CFG_SHUT])
        shut_set[i] = 1'b1;
      if (viol_w[i] && cfg_reg[i][`SPIP_CFG_VSHUT])
        shut_set[i] = 1'b1;
    end
    shut_clr = (wr_fire && avs_address == `SPIP_A_SHUTCLR) ? avs_writedata[3:0] : 4'h0;
  end

  always @(posedge clock) begin
    if (rst)
      port_shut <= 4'h0;
    else
      port_shut <= (port_shut & ~shut_clr) | shut_set;
  end

  ////////////////////////////////////////////////////////////////
  // idle power: a quiet port goes low-power for the next interval
  always @(posedge clock) begin
    if (rst) begin
      seen_reg <= 4'h0;
      eee_lpi  <= 4'h0;
    end else if (tick) begin
      seen_reg <= in_valid ? self_mask : 4'h0;
      for (j = 0; j < 4; j = j + 1)
        eee_lpi[j] <= cfg_reg[j][`SPIP_CFG_EEE] & ~seen_reg[j] & ~(in_valid & self_mask[j]);
    end else begin
      if (in_valid)
        seen_reg <= seen_reg | self_mask;
      // traffic wakes the port at once, without waiting a whole interval
      if (in_valid)
        eee_lpi <= eee_lpi & ~self_mask;
    end
  end

  ////////////////////////////////////////////////////////////////
  // interrupts: [3:0] storm trip, [7:4] violation, [8] oversize
  wire [8:0] ev_w;
  wire [8:0] iclr_w;
  assign ev_w   = {in_valid & oversize, viol_w, storm_ev};
  assign iclr_w = (wr_fire && avs_address == `SPIP_A_ICLR) ? avs_writedata[8:0] : 9'h000;

  always @(posedge clock) begin
    if (rst) begin
      istat_reg <= 9'h000;
      irq       <= 1'b0;
    end else begin
      istat_reg <= (istat_reg & ~iclr_w) | ev_w;
      irq       <= |(((istat_reg & ~iclr_w) | ev_w) & ien_reg);
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then waitrequest low for one edge
  assign wr_fire = avs_write & ~avs_waitrequest;
  assign pidx3   = avs_address[7:5] - `SPIP_PB_FIRST;
  assign pidx    = pidx3[1:0];
  assign pword   = avs_address[4:2];
  assign pblk    = (avs_address[7:5] >= `SPIP_PB_FIRST) && (avs_address[7:5] <= `SPIP_PB_LAST)
                   && (avs_address[1:0] == 2'h0);

  always @(posedge clock) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_next : 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read mux; unmapped and write-only words read as zero
  always @* begin
    rd_next = 32'h00000000;
    if (pblk) begin
      case (pword)
        `SPIP_PW_CFG:  rd_next = {23'h000000, cfg_reg[pidx]};
        3'h1, 3'h2, 3'h3: rd_next = {8'h00, rate_reg[{pidx, pword[1:0]}]};
        `SPIP_PW_VIOL: rd_next = {16'h0000, vcnt_w[pidx*16 +: 16]};
        default:       rd_next = 32'h00000000;
      endcase
    end else begin
      case (avs_address)
        `SPIP_A_CTRL:    rd_next = {31'h00000000, ctrl_reg};
        `SPIP_A_MTU:     rd_next = {18'h00000, mtu_reg};
        `SPIP_A_SECRATE: rd_next = {22'h000000, secrate_reg};
        `SPIP_A_ISTAT:   rd_next = {23'h000000, istat_reg};
        `SPIP_A_IEN:     rd_next = {23'h000000, ien_reg};
        `SPIP_A_PSTAT:   rd_next = {8'h00, over_w, eee_lpi, port_shut};
        default:         rd_next = 32'h00000000;
      endcase
    end
  end

  // register writes take effect at the edge that ends the access
  always @(posedge clock) begin
    if (rst) begin
      ctrl_reg    <= 1'b0;
      mtu_reg     <= `SPIP_MTU_DEF;
      secrate_reg <= `SPIP_SEC_DEF;
      ien_reg     <= 9'h000;
      for (n = 0; n < 4; n = n + 1)
        cfg_reg[n] <= 9'h000;
      for (n = 0; n < 16; n = n + 1)
        rate_reg[n] <= `SPIP_RATE_DEF;
    end else if (wr_fire) begin
      if (pblk) begin
        case (pword)
          `SPIP_PW_CFG: cfg_reg[pidx] <= avs_writedata[8:0];
          3'h1, 3'h2, 3'h3: rate_reg[{pidx, pword[1:0]}] <= clamp_rate(avs_writedata);
          default: ;
        endcase
      end else begin
        case (avs_address)
          `SPIP_A_CTRL:    ctrl_reg    <= avs_writedata[0];
          `SPIP_A_MTU:     mtu_reg     <= clamp_mtu(avs_writedata);
          `SPIP_A_SECRATE: secrate_reg <= clamp_sec(avs_writedata);
          `SPIP_A_IEN:     ien_reg     <= avs_writedata[8:0];
          default: ;
        endcase
      end
    end
  end
endmodule

/* test/spip_top_monitor.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// bus answer timing and the per-frame verdict stream
module spip_top_monitor #(
  parameter INSPECT_CYC = 50
) (
  // clock and reset
  input wire        clock,
  input wire        rst,
  // register bus
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest,
  // frame descriptors in
  input wire        in_valid,
  input wire [1:0]  in_port,
  input wire [13:0] in_len,
  // verdicts out
  input wire        out_valid,
  input wire [1:0]  out_port,
  input wire [3:0]  out_mask,
  input wire        out_drop,
  input wire [3:0]  port_shut
);
  // one clock domain, so one default clocking and reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // a taken request is answered in the very next cycle
  property p_bus_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");
  // the answer stands one cycle only
  property p_bus_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_bus_one: assert property (p_bus_one) else $error("waitrequest low too long");
  // no answer without a request
  property p_bus_idle;
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("answer without request");
  property p_out_follow;
    in_valid |=> out_valid && out_port == $past(in_port);
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("verdict missing");
  property p_out_only;
    !in_valid |=> !out_valid;
  endproperty
  a_out_only: assert property (p_out_only) else $error("verdict without frame");
  property p_drop_mask;
    out_drop |-> out_valid && out_mask == 4'h0;
  endproperty
  a_drop_mask: assert property (p_drop_mask) else $error("dropped frame has egress");
  property p_no_self;
    out_valid |-> !out_mask[out_port];
  endproperty
  a_no_self: assert property (p_no_self) else $error("frame sent back to source");
  property p_shut_drop;
    in_valid && port_shut[in_port] |=> out_drop;
  endproperty
  a_shut_drop: assert property (p_shut_drop) else $error("shut port passed frame");
  property p_oversize;
    in_valid && in_len > 14'h2710 |=> out_drop;
  endproperty
  a_oversize: assert property (p_oversize) else $error("oversize frame passed");
endmodule
bind spip_top spip_top_monitor #(.INSPECT_CYC(INSPECT_CYC)) u_mon (
  .clock(clock), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_port(in_port), .in_len(in_len),
  .out_valid(out_valid), .out_port(out_port), .out_mask(out_mask), .out_drop(out_drop),
  .port_shut(port_shut));

/* test/spip_link_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// link partner: hands received frame descriptors to the switch
module spip_link_model (
  // clock
  input wire        clock,
  // descriptor towards the switch
  output reg        in_valid,
  output reg [1:0]  in_port,
  output reg [1:0]  in_class,
  output reg [13:0] in_len,
  output reg [47:0] in_sa,
  output reg [3:0]  in_dst_mask
);
  // idle at time zero
  initial begin
    in_valid = 1'b0;
    in_port = 2'h0;
    in_class = 2'h0;
    in_len = 14'h0;
    in_sa = 48'h0;
    in_dst_mask = 4'h0;
  end
  // one-cycle descriptor; length, address and mask are inverted afterwards so stale values never look valid
  task send(input [1:0] p, input [1:0] c, input [13:0] l, input [47:0] s, input [3:0] m);
    begin
      @(posedge clock);
      in_valid <= 1'b1;
      in_port <= p;
      in_class <= c;
      in_len <= l;
      in_sa <= s;
      in_dst_mask <= m;
      @(posedge clock);
      in_valid <= 1'b0;
      in_len <= ~l;
      in_sa <= ~s;
      in_dst_mask <= ~m;
    end
  endtask
endmodule

/* test/tb_switch_port_ingress_policy.sv */
`timescale 1ns/1ps
`include "spip_consts.vh"
module tb_switch_port_ingress_policy;
  localparam CYC = 50; // short inspection interval
  // bus master and clock
  reg         clock;
  reg         rst;
  reg  [7:0]  avs_address;
  reg         avs_read;
  reg         avs_write;
  reg  [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  // stream and status
  wire        in_valid;
  wire [1:0]  in_port;
  wire [1:0]  in_class;
  wire [13:0] in_len;
  wire [47:0] in_sa;
  wire [3:0]  in_dst_mask;
  wire        out_valid;
  wire [1:0]  out_port;
  wire [3:0]  out_mask;
  wire        out_drop;
  wire [3:0]  port_shut;
  wire [3:0]  eee_lpi;
  wire        irq;
  // scoreboard state
  integer     errors;
  integer     checked;
  integer     k;
  reg  [31:0] seed;
  reg  [3:0]  prot;
  reg  [3:0]  shut;
  reg  [13:0] mtu;
  reg  [7:0]  fe;
  reg  [7:0]  fq[$];
  reg  [31:0] rq[$];

  spip_top #(.INSPECT_CYC(CYC)) dut (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
    .in_port(in_port), .in_class(in_class), .in_len(in_len), .in_sa(in_sa),
    .in_dst_mask(in_dst_mask), .out_valid(out_valid), .out_port(out_port), .out_mask(out_mask),
    .out_drop(out_drop), .port_shut(port_shut), .eee_lpi(eee_lpi), .irq(irq));
  spip_link_model link (.clock(clock), .in_valid(in_valid), .in_port(in_port), .in_class(in_class),
    .in_len(in_len), .in_sa(in_sa), .in_dst_mask(in_dst_mask));

  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("counts: %0d checked, %0d errors", checked, errors);
      if (errors == 0 && checked > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // one bus access; a read notes its expected data for the watcher
  task bus(input w, input [7:0] a, input [31:0] d);
    integer i;
    begin
      i = 0;
      if (!w) rq.push_back(d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= w ? d : 32'h0;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) begin
        i = i + 1;
        if (i > 20) begin
          errors = errors + 1;
          wrap_up;
        end
        @(posedge clock);
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task clamp(input [7:0] a, input [31:0] w, input [31:0] e);
    begin
      bus(1'b1, a, w);
      bus(1'b0, a, e);
    end
  endtask
  // one frame; the expected verdict comes from the bench's own copy of the settings
  task frame(input [1:0] p, input [1:0] c, input [13:0] l, input [47:0] s, input [3:0] m,
             input chk, input bad);
    reg       dr;
    reg [3:0] mk;
    begin
      dr = bad | shut[p] | (l > mtu);
      mk = (c == `SPIP_CLS_KNOWN) ? m : 4'hf;
      mk = mk & ~(4'h1 << p) & ~shut & (prot[p] ? ~prot : 4'hf);
      fq.push_back({chk, dr, p, dr ? 4'h0 : mk});
      link.send(p, c, l, s, m);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // watcher: oldest note against each result as it appears
  always @(posedge clock) begin
    if (out_valid === 1'b1) begin
      if (fq.size() == 0) begin
        errors = errors + 1;
        $display("Error out_valid expected 0 seen 1");
      end else begin
        fe = fq.pop_front();
        if (fe[7]) begin
          check("out_drop", out_drop, fe[6]);
          check("out_port", out_port, fe[5:4]);
          check("out_mask", out_mask, fe[3:0]);
        end
      end
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      check("avs_readdata", avs_readdata, rq.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge clock);
    errors = errors + 1;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    checked = 0;
    seed = 32'h9df29e02;
    prot = 4'h0;
    shut = 4'h0;
    mtu = `SPIP_MTU_DEF;
    rst = 1'b1;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    // reset values, unmapped place reads zero
    bus(1'b0, `SPIP_A_CTRL, 32'h0);
    bus(1'b0, `SPIP_A_MTU, 32'h5f2);
    bus(1'b0, `SPIP_A_SECRATE, 32'h64);
    bus(1'b0, 8'h40, 32'h0);
    bus(1'b0, 8'h44, 32'h2710);
    bus(1'b0, 8'h48, 32'h2710);
    bus(1'b0, 8'h4c, 32'h2710);
    bus(1'b0, 8'hb0, 32'h0);
    bus(1'b0, 8'hfc, 32'h0);
    bus(1'b0, `SPIP_A_IEN, 32'h0);
    $display("test defaults done");
    // range limits on MTU, rate and learning rate writes, both ends
    clamp(`SPIP_A_MTU, 32'h2711, 32'h2710);
    clamp(`SPIP_A_MTU, 32'h5ed, 32'h5ee);
    clamp(8'h44, 32'hf, 32'h10);
    clamp(8'h4c, 32'h989681, 32'h989680);
    clamp(`SPIP_A_SECRATE, 32'h0, 32'h1);
    clamp(`SPIP_A_SECRATE, 32'h259, 32'h258);
    mtu = 14'h5ee;
    $display("test limits done");
    // random flooding and length limit, both edges of the limit
    frame(2'h1, `SPIP_CLS_BC, 14'h5ee, 48'h1, 4'h0, 1'b1, 1'b0);
    frame(2'h1, `SPIP_CLS_BC, 14'h5ef, 48'h1, 4'h0, 1'b1, 1'b0);
    frame(2'h0, `SPIP_CLS_KNOWN, 14'h2711, 48'h1, 4'h2, 1'b1, 1'b0);
    for (k = 0; k < 24; k = k + 1) begin
      seed = xs(seed);
      frame(seed[1:0], seed[3:2], {3'h0, seed[14:4]} + 14'h40, {seed, seed[15:0]}, seed[19:16],
            1'b1, 1'b0);
    end
    $display("test flooding done");
    // isolation between protected ports
    bus(1'b1, 8'h40, 32'h20);
    bus(1'b1, 8'h60, 32'h20);
    prot = 4'h3;
    frame(2'h0, `SPIP_CLS_BC, 14'h40, 48'h2, 4'h0, 1'b1, 1'b0);
    frame(2'h2, `SPIP_CLS_UMC, 14'h40, 48'h2, 4'h0, 1'b1, 1'b0);
    frame(2'h1, `SPIP_CLS_KNOWN, 14'h40, 48'h2, 4'h1, 1'b1, 1'b0);
    bus(1'b1, 8'h40, 32'h0);
    bus(1'b1, 8'h60, 32'h0);
    prot = 4'h0;
    $display("test isolation done");
    // storm, drop action: broadcast on port 1 far over 16 bits per interval
    bus(1'b1, 8'h64, 32'h10);
    bus(1'b1, 8'h60, 32'h3);
    for (k = 0; k < 15; k = k + 1) begin
      frame(2'h1, `SPIP_CLS_BC, 14'h40, 48'h3, 4'h0, 1'b0, 1'b0);
      repeat (8) @(posedge clock);
    end
    frame(2'h1, `SPIP_CLS_BC, 14'h40, 48'h3, 4'h0, 1'b1, 1'b1);
    frame(2'h1, `SPIP_CLS_UMC, 14'h40, 48'h3, 4'h0, 1'b1, 1'b0);
    bus(1'b0, `SPIP_A_ISTAT, 32'h102);
    check("irq", irq, 1'b0);
    bus(1'b1, `SPIP_A_IEN, 32'h2);
    repeat (3) @(posedge clock);
    check("irq", irq, 1'b1);
    bus(1'b1, 8'h60, 32'h0);
    repeat (2 * CYC) @(posedge clock);
    bus(1'b1, `SPIP_A_ICLR, 32'h102);
    bus(1'b0, `SPIP_A_ISTAT, 32'h0);
    repeat (3) @(posedge clock);
    check("irq", irq, 1'b0);
    $display("test storm drop done");
    // storm, shutdown action on port 2 unknown unicast
    bus(1'b1, 8'h8c, 32'h10);
    bus(1'b1, 8'h80, 32'h19);
    for (k = 0; k < 15; k = k + 1) begin
      frame(2'h2, `SPIP_CLS_UUC, 14'h40, 48'h4, 4'h0, 1'b0, 1'b0);
      repeat (8) @(posedge clock);
    end
    bus(1'b1, 8'h80, 32'h0);
    check("port_shut", port_shut, 4'h4);
    shut = 4'h4;
    frame(2'h0, `SPIP_CLS_KNOWN, 14'h40, 48'h4, 4'h4, 1'b1, 1'b0);
    frame(2'h2, `SPIP_CLS_BC, 14'h40, 48'h4, 4'h0, 1'b1, 1'b0);
    bus(1'b1, `SPIP_A_SHUTCLR, 32'h4);
    shut = 4'h0;
    repeat (2) @(posedge clock);
    check("port_shut", port_shut, 4'h0);
    $display("test storm shutdown done");
    // source lock on port 3: first address learned, another one refused
    bus(1'b1, `SPIP_A_CTRL, 32'h1);
    bus(1'b1, 8'ha0, 32'h80);
    frame(2'h3, `SPIP_CLS_KNOWN, 14'h40, 48'ha1, 4'h1, 1'b1, 1'b0);
    frame(2'h3, `SPIP_CLS_KNOWN, 14'h40, 48'hb2, 4'h1, 1'b1, 1'b1);
    frame(2'h3, `SPIP_CLS_KNOWN, 14'h40, 48'ha1, 4'h1, 1'b1, 1'b0);
    bus(1'b0, 8'hb0, 32'h1);
    bus(1'b0, `SPIP_A_ISTAT, 32'h84);
    $display("test source lock done");
    // idle power on port 0 after a quiet interval, left on traffic
    bus(1'b1, 8'h40, 32'h40);
    repeat (2 * CYC + 2) @(posedge clock);
    check("eee_lpi", eee_lpi[0], 1'b1);
    frame(2'h0, `SPIP_CLS_BC, 14'h40, 48'h5, 4'h0, 1'b1, 1'b0);
    repeat (2) @(posedge clock);
    check("eee_lpi", eee_lpi[0], 1'b0);
    $display("test idle power done");
    check("pending", fq.size(), 32'h0);
    wrap_up;
  end
endmodule
